// ### lpsd_pkg.sv
// Constants shared by the LED PWM shift driver core and its FIFO
package lpsd_pkg;
	// ==========================================================
	// Shift register and frame layout
	localparam int SHIFT_BITS   = 224;
	localparam int CHANNELS     = 12;
	localparam int GROUP_CH     = 4;
	localparam int GRAY_W       = 16;
	localparam int BRIGHT_W     = 7;
	localparam int GRAY_LSB     = 0;
	localparam int RED_BR_LSB   = 192;
	localparam int GREEN_BR_LSB = 199;
	localparam int BLUE_BR_LSB  = 206;
	localparam int EXT_SEL_BIT  = 213;
	localparam int FRAME_CNT_W  = 8;
	// ==========================================================
	// Snoop FIFO
	localparam int SNOOP_W     = 16;
	localparam int SNOOP_DEPTH = 16;
	localparam int WORD_CNT_W  = 4;
	// ==========================================================
	// Timing: internal grayscale clock divider
	localparam int INT_DIV      = 1;
	localparam int DIV_W        = 8;
	// ==========================================================
	// Register map, byte offsets
	localparam logic [4:0] CTRL_OFS   = 5'h00;
	localparam logic [4:0] STAT_OFS   = 5'h04;
	localparam logic [4:0] SNOOP_OFS  = 5'h08;
	localparam logic [4:0] BRIGHT_OFS = 5'h0c;
	localparam logic [4:0] GCNT_OFS   = 5'h10;
	// Control fields
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_LATCH = 1;
	localparam logic CTRL_RUN_RST = 1'b0;
	// Status fields
	localparam int ST_HOT   = 0;
	localparam int ST_GND   = 1;
	localparam int ST_EXT   = 2;
	localparam int ST_OVF   = 3;
	localparam int ST_AVAIL = 4;
	localparam int ST_FCNT  = 8;
	// Reset values
	localparam logic [SHIFT_BITS-1:0] SHIFT_RST = '0;
	localparam logic [GRAY_W-1:0]     GRAY_RST  = 16'h0000;
	localparam logic [BRIGHT_W-1:0]   BRIGHT_RST = 7'h00;
endpackage : lpsd_pkg

// ### lpsd_fifo.sv
// Parameterised valid/ready FIFO with registered flags
`timescale 1ns/10ps
`default_nettype none
module lpsd_fifo
	import lpsd_pkg::*;
#(
	parameter int WIDTH = SNOOP_W,
	parameter int DEPTH = SNOOP_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	// ==========================================================
	// Storage and pointers
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Flags are flops so full and empty never glitch on the ports
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_q        <= '0;
			rd_q        <= '0;
			cnt_q       <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end else if (ce_i) begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q       <= cnt_d;
			in_ready_o  <= (cnt_d != (AW+1)'(DEPTH));
			out_valid_o <= (cnt_d != '0);
		end
	end
endmodule // lpsd_fifo
`default_nettype wire

// ### lpsd_core.sv
// LED PWM shift driver core: serial chain, latch, PWM and register slave
`timescale 1ns/10ps
`default_nettype none
module lpsd_core
	import lpsd_pkg::*;
#(
	parameter int DIV   = INT_DIV,
	parameter int FIFO_D = SNOOP_DEPTH
) (
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	input  wire logic          shift_clk_in_i,
	input  wire logic          serial_in_i,
	input  wire logic          overheat_i,
	input  wire logic          current_set_gnd_i,
	input  wire logic [4:0]    avs_address_i,
	input  wire logic          avs_read_i,
	input  wire logic          avs_write_i,
	input  wire logic [31:0]   avs_writedata_i,
	input  wire logic [3:0]    avs_byteenable_i,
	output logic      [31:0]   avs_readdata_o,
	output logic               avs_waitrequest_o,
	output logic               serial_out_o,
	output logic               shift_clk_out_o,
	output logic      [3:0]    red_sink_o,
	output logic      [3:0]    green_sink_o,
	output logic      [3:0]    blue_sink_o,
	output logic [BRIGHT_W-1:0] red_brightness_o,
	output logic [BRIGHT_W-1:0] green_brightness_o,
	output logic [BRIGHT_W-1:0] blue_brightness_o,
	output logic               snoop_ready_o
);
	// ==========================================================
	// Pin synchronisers
	logic       sck_s1_q;
	logic       sck_s2_q;
	logic       sck_s3_q;
	logic       sdi_s1_q;
	logic       sdi_s2_q;
	logic [1:0] flt_s1_q;
	logic [1:0] flt_s2_q;
	logic       sck_rise;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
			flt_s1_q <= 2'h0;
			flt_s2_q <= 2'h0;
		end else if (ce_i) begin
			sck_s1_q <= shift_clk_in_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			sdi_s1_q <= serial_in_i;
			sdi_s2_q <= sdi_s1_q;
			flt_s1_q <= {current_set_gnd_i, overheat_i};
			flt_s2_q <= flt_s1_q;
		end
	end

	// Edge found on the second stage; the first stage feeds nothing else
	assign sck_rise = sck_s2_q & ~sck_s3_q;

	// ==========================================================
	// Shift register and chain outputs
	logic [SHIFT_BITS-1:0] shift_q;
	logic                  sck_dly_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_q <= SHIFT_RST;
		end else if (ce_i && sck_rise) begin
			shift_q <= {shift_q[SHIFT_BITS-2:0], sdi_s2_q};
		end
	end

	// Registered copy tracks the MSB, so it moves only on a shift edge
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_out_o <= 1'b0;
		end else if (ce_i && sck_rise) begin
			serial_out_o <= shift_q[SHIFT_BITS-2];
		end
	end

	// Clock out rises two cycles after the data moved: downstream setup margin
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_dly_q       <= 1'b0;
			shift_clk_out_o <= 1'b0;
		end else if (ce_i) begin
			sck_dly_q       <= sck_s3_q;
			shift_clk_out_o <= sck_dly_q;
		end
	end

	// ==========================================================
	// Word snoop into the FIFO
	logic [WORD_CNT_W-1:0]  word_cnt_q;
	logic [FRAME_CNT_W-1:0] frame_cnt_q;
	logic                   word_push;
	logic                   fifo_ready;
	logic                   fifo_valid;
	logic                   fifo_pop;
	logic [SNOOP_W-1:0]     fifo_data;
	logic                   ovf_q;

	assign word_push = sck_rise & (word_cnt_q == '1);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_cnt_q <= '0;
		end else if (ce_i && sck_rise) begin
			word_cnt_q <= word_cnt_q + 1'b1;
		end
	end

	lpsd_fifo #(
		.WIDTH (SNOOP_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.ce_i        (ce_i),
		.in_valid_i  (word_push),
		.in_ready_o  (fifo_ready),
		.in_data_i   ({shift_q[SNOOP_W-2:0], sdi_s2_q}),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	assign snoop_ready_o = fifo_ready;

	// ==========================================================
	// Avalon-MM slave, one wait cycle per access
	logic       req;
	logic       acc;
	logic       run_q;
	logic       latch_q;
	logic       ext_sel_q;
	logic [15:0] gcnt_q;
	logic       wr_ctrl;
	logic       wr_stat;

	assign req      = avs_read_i | avs_write_i;
	assign acc      = req & ~avs_waitrequest_o;
	assign wr_ctrl  = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == CTRL_OFS);
	assign wr_stat  = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == STAT_OFS);
	assign fifo_pop = acc & avs_read_i & (avs_address_i == SNOOP_OFS);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if (ce_i) begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
			case (avs_address_i)
				CTRL_OFS: begin
					avs_readdata_o <= {31'h00000000, run_q};
				end
				STAT_OFS: begin
					avs_readdata_o <= {16'h0000, frame_cnt_q, 3'h0, fifo_valid,
						ovf_q, ext_sel_q, flt_s2_q};
				end
				SNOOP_OFS: begin
					avs_readdata_o <= {15'h0000, fifo_valid, fifo_data};
				end
				BRIGHT_OFS: begin
					avs_readdata_o <= {11'h000, blue_brightness_o,
						green_brightness_o, red_brightness_o};
				end
				GCNT_OFS: begin
					avs_readdata_o <= {16'h0000, gcnt_q};
				end
				default: begin
					avs_readdata_o <= 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_q   <= CTRL_RUN_RST;
			latch_q <= 1'b0;
		end else if (ce_i) begin
			latch_q <= wr_ctrl & avs_writedata_i[CTRL_LATCH];
			if (wr_ctrl) begin
				run_q <= avs_writedata_i[CTRL_RUN];
			end
		end
	end

	// Overflow sticky: a lost word in the clearing cycle still sets it
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_q <= 1'b0;
		end else if (ce_i) begin
			if (word_push && !fifo_ready) begin
				ovf_q <= 1'b1;
			end else if (wr_stat && avs_writedata_i[ST_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end

	// Bits shifted since the last latch, saturating
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frame_cnt_q <= '0;
		end else if (ce_i) begin
			if (latch_q) begin
				frame_cnt_q <= '0;
			end else if (sck_rise && frame_cnt_q != '1) begin
				frame_cnt_q <= frame_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// Latched configuration
	logic [GRAY_W-1:0] gray_q [CHANNELS];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			red_brightness_o   <= BRIGHT_RST;
			green_brightness_o <= BRIGHT_RST;
			blue_brightness_o  <= BRIGHT_RST;
			ext_sel_q          <= 1'b0;
		end else if (ce_i && latch_q) begin
			red_brightness_o   <= shift_q[RED_BR_LSB +: BRIGHT_W];
			green_brightness_o <= shift_q[GREEN_BR_LSB +: BRIGHT_W];
			blue_brightness_o  <= shift_q[BLUE_BR_LSB +: BRIGHT_W];
			ext_sel_q          <= shift_q[EXT_SEL_BIT];
		end
	end

	// ==========================================================
	// Grayscale clock and counter
	logic [DIV_W-1:0] div_q;
	logic             int_tick;
	logic             gs_tick;

	assign int_tick = (div_q == DIV_W'(DIV - 1));
	assign gs_tick  = ext_sel_q ? sck_rise : int_tick;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q <= '0;
		end else if (ce_i) begin
			div_q <= int_tick ? '0 : div_q + 1'b1;
		end
	end

	// Counter wraps after 65536 ticks, one display period
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gcnt_q <= 16'h0000;
		end else if (ce_i) begin
			if (!run_q) begin
				gcnt_q <= 16'h0000;
			end else if (gs_tick) begin
				gcnt_q <= gcnt_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// Per-channel PWM sinks
	logic [CHANNELS-1:0] sink_q;
	logic                force_off;

	assign force_off = flt_s2_q[ST_HOT] | flt_s2_q[ST_GND];

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				gray_q[ch] <= GRAY_RST;
				sink_q[ch] <= 1'b0;
			end else if (ce_i) begin
				if (latch_q) begin
					gray_q[ch] <= shift_q[GRAY_LSB + ch*GRAY_W +: GRAY_W];
				end
				// Forced off is level-driven, so sinks restart once it drops
				sink_q[ch] <= run_q & ~force_off & (gcnt_q < gray_q[ch]);
			end
		end
	end

	assign red_sink_o   = sink_q[0 +: GROUP_CH];
	assign green_sink_o = sink_q[GROUP_CH +: GROUP_CH];
	assign blue_sink_o  = sink_q[2*GROUP_CH +: GROUP_CH];
endmodule // lpsd_core
`default_nettype wire

// ### lpsd_core_asserts.sv
// Concurrent checks on the LED PWM shift driver core ports
`timescale 1ns/10ps
`default_nettype none
module lpsd_core_asserts
	import lpsd_pkg::*;
(
	input wire logic                clk_i,
	input wire logic                rstn_i,
	input wire logic                shift_clk_in_i,
	input wire logic                overheat_i,
	input wire logic                current_set_gnd_i,
	input wire logic                serial_out_o,
	input wire logic                shift_clk_out_o,
	input wire logic [3:0]          red_sink_o,
	input wire logic [3:0]          green_sink_o,
	input wire logic [3:0]          blue_sink_o,
	input wire logic [BRIGHT_W-1:0] red_brightness_o,
	input wire logic [BRIGHT_W-1:0] green_brightness_o,
	input wire logic [BRIGHT_W-1:0] blue_brightness_o
);
	// ====
	// Port relations
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic [11:0] sinks;
	logic [20:0] bright;
	assign sinks = {blue_sink_o, green_sink_o, red_sink_o};
	assign bright = {blue_brightness_o, green_brightness_o, red_brightness_o};
	a_out_then_clk: assert property ($changed(serial_out_o) |-> ##2 $rose(shift_clk_out_o))
		else $error("serial out moved without a clock copy");
	a_out_steady: assert property (shift_clk_out_o |-> $stable(serial_out_o))
		else $error("serial out moved while clock copy high");
	a_clk_regen: assert property ($rose(shift_clk_in_i) |-> ##[3:7] $rose(shift_clk_out_o))
		else $error("shift clock not regenerated");
	a_clk_width: assert property ($rose(shift_clk_out_o) |-> shift_clk_out_o[*4] ##1 !shift_clk_out_o)
		else $error("clock copy high time differs from input");
	a_hot_off: assert property (overheat_i[*5] |-> sinks == 12'h000)
		else $error("sink on during overheat");
	a_gnd_off: assert property (current_set_gnd_i[*5] |-> sinks == 12'h000)
		else $error("sink on with reference pin grounded");
	a_bright_once: assert property ($changed(bright) |=> $stable(bright))
		else $error("brightness changed twice in a row");
	a_gnd_hot_idle: assert property ((overheat_i || current_set_gnd_i)[*6] |-> $stable(sinks))
		else $error("sinks moving while forced off");
	c_shift: cover property ($rose(shift_clk_out_o));
	c_latch: cover property ($changed(bright));
	c_hot: cover property (overheat_i[*5]);
endmodule // lpsd_core_asserts
bind lpsd_core lpsd_core_asserts chk_u (.clk_i(clk_i), .rstn_i(rstn_i),
	.shift_clk_in_i(shift_clk_in_i), .overheat_i(overheat_i),
	.current_set_gnd_i(current_set_gnd_i), .serial_out_o(serial_out_o),
	.shift_clk_out_o(shift_clk_out_o), .red_sink_o(red_sink_o),
	.green_sink_o(green_sink_o), .blue_sink_o(blue_sink_o),
	.red_brightness_o(red_brightness_o), .green_brightness_o(green_brightness_o),
	.blue_brightness_o(blue_brightness_o));
`default_nettype wire

// ### lpsd_host_model.sv
// Host controller model driving the shift clock and serial data
`timescale 1ns/10ps
`default_nettype none
module lpsd_host_model (
	input  wire logic clk_i,
	output logic      shift_clk_o,
	output logic      serial_o
);
	// ====
	// Bit timing: 4 clocks low, 4 high, 800 ns a bit
	initial begin
		shift_clk_o = 1'b0;
		serial_o = 1'b0;
	end
	// Call right after a clock edge; clock stands low between frames
	task automatic send(input logic [447:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			shift_clk_o <= 1'b0;
			serial_o <= bits[i];
			repeat (4) @(posedge clk_i);
			shift_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		shift_clk_o <= 1'b0;
		// Hold time over: stale level must not look valid
		serial_o <= ~bits[0];
	endtask
endmodule // lpsd_host_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the LED PWM shift driver core
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lpsd_pkg::*;
	// ====
	// Signals
	logic                clk_i = 1'b0, rstn_i = 1'b0, overheat = 1'b0, gnd_short = 1'b0;
	logic                sck, sdi, wreq, sdo, sco, snoop_rdy;
	logic                rd = 1'b0, wr = 1'b0, sco_q = 1'b0;
	logic [4:0]          adr = 5'h00;
	logic [31:0]         wdat = 32'h0, rdat;
	logic [3:0]          red, grn, blu;
	logic [BRIGHT_W-1:0] br_r, br_g, br_b;
	logic [223:0]        frame;
	logic                cap[$];
	int                  miscompares = 0, checks = 0, cyc = 0;
	always #50 clk_i = ~clk_i;
	lpsd_host_model host_u (.clk_i(clk_i), .shift_clk_o(sck), .serial_o(sdi));
	lpsd_core #(.DIV(1), .FIFO_D(16)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
		.shift_clk_in_i(sck), .serial_in_i(sdi), .overheat_i(overheat),
		.current_set_gnd_i(gnd_short), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .serial_out_o(sdo),
		.shift_clk_out_o(sco), .red_sink_o(red), .green_sink_o(grn), .blue_sink_o(blu),
		.red_brightness_o(br_r), .green_brightness_o(br_g), .blue_brightness_o(br_b),
		.snoop_ready_o(snoop_rdy));
	// ====
	// Capture serial out at each rise of the clock copy; timeout
	always @(posedge clk_i) begin
		if (sco === 1'b1 && sco_q === 1'b0)
			cap.push_back(sdo);
		sco_q <= sco;
		cyc++;
		if (cyc == 12000) begin
			miscompares++;
			end_sim();
		end
	end
	// ====
	// Shared tasks
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk_i); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrt(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input string what, input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(what, q, exp);
	endtask
	// ====
	// Scenarios
	task automatic t_regs();
		rdc("ctrl", CTRL_OFS, 32'h0);
		rdc("status", STAT_OFS, 32'h0);
		wrt(5'h14, 32'hffff_ffff);
		rdc("unmapped", 5'h14, 32'h0);
		rdc("bright", BRIGHT_OFS, 32'h0);
	endtask
	// Two frames: the first comes out behind 223 reset zeros, FIFO overflows
	// Serial out is the MSB itself, so the first frame bit shows after shift 224
	task automatic t_chain();
		logic [447:0] two;
		two = {frame, frame};
		host_u.send(two, 448);
		repeat (8) @(posedge clk_i);
		check("bits out", cap.size(), 448);
		for (int i = 0; i < 448; i++)
			check("serial out", cap[i], (i < 223) ? 1'b0 : two[670 - i]);
		check("fifo full", snoop_rdy, 1'b0);
		rdc("status", STAT_OFS, 32'h0000_ff18);
		for (int k = 0; k < 16; k++)
			rdc("snoop", SNOOP_OFS, {15'h0, 1'b1, frame[223 - 16 * (k % 14) -: 16]});
		wrt(STAT_OFS, 32'h8);
		wrt(CTRL_OFS, 32'h2);
		repeat (3) @(posedge clk_i);
		check("red br", br_r, frame[RED_BR_LSB +: BRIGHT_W]);
		check("grn br", br_g, frame[GREEN_BR_LSB +: BRIGHT_W]);
		check("blu br", br_b, frame[BLUE_BR_LSB +: BRIGHT_W]);
		rdc("bright reg", BRIGHT_OFS, {11'h0, frame[212:192]});
		rdc("status clear", STAT_OFS, 32'h0);
	endtask
	task automatic t_pwm();
		int n[3];
		logic [7:0] rest;
		rest = '0;
		n = '{0, 0, 0};
		wrt(CTRL_OFS, 32'h1);
		repeat (40) begin
			@(posedge clk_i);
			n[0] += red[0];
			n[1] += grn[0];
			n[2] += blu[0];
			rest |= {red[3:2], grn[3:1], blu[3:1]};
		end
		check("red0 on", n[0], 3);
		check("grn0 on", n[1], 2);
		check("blu0 on", n[2], 1);
		check("idle sinks", rest, 0);
		check("red1 on", red[1], 1'b1);
	endtask
	task automatic t_force(input int sel);
		@(posedge clk_i);
		if (sel == ST_HOT)
			overheat <= 1'b1;
		else
			gnd_short <= 1'b1;
		repeat (6) @(posedge clk_i);
		check("forced off", {red, grn, blu}, 12'h0);
		rdc("status flag", STAT_OFS, 32'h1 << sel);
		@(posedge clk_i);
		overheat <= 1'b0;
		gnd_short <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("resumed", red[1], 1'b1);
	endtask
	// ====
	// Main sequence
	initial begin
		frame = '0;
		frame[15:0] = 16'h0003;
		frame[31:16] = 16'hffff;
		frame[79:64] = 16'h0002;
		frame[143:128] = 16'h0001;
		frame[RED_BR_LSB +: BRIGHT_W] = 7'h55;
		frame[GREEN_BR_LSB +: BRIGHT_W] = 7'h2a;
		frame[BLUE_BR_LSB +: BRIGHT_W] = 7'h7f;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_chain();
		t_pwm();
		t_force(ST_HOT);
		t_force(ST_GND);
		end_sim();
	end
endmodule // testbench
`default_nettype wire
